// [rtl/adc_sequencer.v]
`timescale 1ns/100ps
`include "adc_seq_map.vh"
// Notes on behaviour
// - each selected channel takes 18 rising input clock edges, start uncertainty included
// - one sample pulse freezes every track/hold at the same instant
// - in a pair entry, lowest select bit chooses which input is positive
// - polarity loaded by a write applies to the conversion that write starts
// - unipolar pair with positive below negative stores zero
// - idle write with inhibit and power-down clear samples, starts, and updates its addressed entry; during a scan it only updates the entry
// - busy_n low from start until every channel of the running scan is converted (only the addressed one after a single-channel start)
// - results land in RAM, valid once busy_n returns high
// - reads step through selected channels ascending, wrapping to lowest
// - pair at 001 is 1+/0-, pair at 110 is 6+/7-
// - write with inhibit set moves read pointer (unless a scan ends in that cycle) and config, no start
// - sampling on the write, busy_n falls at the same edge as the sample pulse
// - configuration entry is stored at the end of the write strobe
// - while powered down, writes accepted, data reads give zero, no starts unless the write clears power-down
module adc_sequencer #(
    parameter CHANS     = 8,
    parameter CNT_W     = 5
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         addr,
    input  wire [7:0]   wdata,
    input  wire         wr,
    input  wire         rd,
    output reg  [7:0]   rdata,
    input  wire         conv_clk,
    input  wire [7:0]   adc_code,
    input  wire         adc_below,
    output reg          busy_n,
    output reg          sample_hold,
    output reg  [2:0]   conv_pos,
    output reg  [2:0]   conv_neg,
    output reg          conv_pair,
    output reg          conv_signed,
    output reg          power_down
);

    // ****************************************
    // states and counts
    // ****************************************
    // a count of 0 marks the first rise, so the last rise of a channel is one short
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;
    localparam integer     LAST_INT = `CLKS_PER_CHAN - 1;
    localparam [CNT_W-1:0] LAST_CNT = LAST_INT[CNT_W-1:0];

    // ****************************************
    // storage
    // ****************************************
    reg  [7:0]          ram [0:CHANS-1];
    reg  [CHANS-1:0]    sel_mask;       // channels taking part in a full scan
    reg  [CHANS-1:0]    pair_en;        // even slot holds a pair
    reg  [CHANS-1:0]    pair_swap;      // odd input is positive
    reg  [CHANS-1:0]    signed_en;
    reg  [CHANS-1:0]    run_mask;       // mask frozen for the running scan
    reg  [2:0]          rd_ptr;
    reg  [2:0]          cur_chan;
    reg  [CNT_W-1:0]    clk_cnt;
    reg                 state;
    reg                 conv_clk_d;

    // ****************************************
    // bus decode
    // ****************************************
    // fields of the byte on the bus, meaningful only in a strobe cycle
    wire [2:0]          w_chan  = wdata[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
    wire [2:0]          w_even  = {w_chan[2:1], 1'b0};
    wire                w_pd    = wdata[`CFG_POWER_DOWN];
    wire                w_inh   = wdata[`CFG_INHIBIT];
    wire                data_wr = wr && (addr == `ADDR_DATA);
    wire                data_rd = rd && (addr == `ADDR_DATA);
    // powered down, a data read neither returns RAM nor moves the pointer
    wire                ram_rd  = data_rd && !power_down;
    // new power-down value counts, so a write that powers up may also start
    wire                start   = data_wr && !w_inh && !w_pd && state == ST_IDLE;
    wire                clk_rise = conv_clk && !conv_clk_d;

    // ****************************************
    // helpers
    // ****************************************
    // next set bit above cur, wrapping; returns cur when nothing else is set
    function [2:0] next_sel;
        input [7:0] m;
        input [2:0] cur;
        integer k;
        reg     hit;
        reg [2:0] idx;
        begin
            next_sel = cur;
            hit = 1'b0;
            // eight steps visit every slot once and end back at cur
            for (k = 1; k <= 8; k = k + 1) begin
                idx = cur + k[2:0];
                if (!hit && m[idx]) begin
                    next_sel = idx;
                    hit = 1'b1;
                end
            end
        end
    endfunction

    // mask of the scan a starting write requests, with its own entry applied
    function [7:0] scan_mask;
        input [7:0] old;
        input [7:0] d;
        reg   [2:0] ch;
        reg   [2:0] ev;
        begin
            ch = d[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
            ev = {ch[2:1], 1'b0};
            scan_mask = old;
            // a pair takes its even slot; the odd slot is not a channel of its own
            if (d[`CFG_PAIR]) begin
                scan_mask[ev] = 1'b1;
                scan_mask[ev + 3'h1] = 1'b0;
            end else begin
                scan_mask[ch] = 1'b1;
            end
            // a single-channel start narrows this scan only; the stored mask is kept
            if (d[`CFG_SINGLE])
                scan_mask = 8'h01 << (d[`CFG_PAIR] ? ev : ch);
        end
    endfunction

    // ****************************************
    // scan events
    // ****************************************
    // a commit closes one channel; the last commit also closes the scan
    wire                commit    = state == ST_CONV && clk_rise && clk_cnt == LAST_CNT;
    wire [2:0]          next_chan = next_sel(run_mask, cur_chan);
    wire                scan_end  = commit && next_chan <= cur_chan;

    // ****************************************
    // configuration entries
    // ****************************************
    // entry lands in the strobe cycle, before the scan's first channel is set up
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_mask   <= `RST_MASK;
            pair_en    <= `RST_MASK;
            pair_swap  <= `RST_MASK;
            signed_en  <= `RST_MASK;
            power_down <= 1'b0;
        end else if (data_wr) begin
            // power-down follows every data write, so one write may also wake the block
            power_down <= w_pd;
            // a pair written at either address of the two lands in the even slot
            if (wdata[`CFG_PAIR]) begin
                sel_mask[w_even]           <= 1'b1;
                sel_mask[w_even + 3'h1]    <= 1'b0;
                pair_en[w_even]            <= 1'b1;
                pair_swap[w_even]          <= w_chan[0];
                signed_en[w_even]          <= wdata[`CFG_SIGNED];
            end else begin
                // a single-ended entry on either slot of a pair breaks up the pair there
                sel_mask[w_chan]           <= 1'b1;
                pair_en[w_even]            <= 1'b0;
                signed_en[w_chan]          <= wdata[`CFG_SIGNED];
            end
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // scan walks run_mask ascending; count restarts at each channel
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state       <= ST_IDLE;
            busy_n      <= 1'b1;
            sample_hold <= 1'b0;
            run_mask    <= `RST_MASK;
            cur_chan    <= 3'h0;
            clk_cnt     <= {CNT_W{1'b0}};
            conv_clk_d  <= 1'b0;
        end else begin
            // edge detector on the conversion clock, which runs free
            conv_clk_d  <= conv_clk;
            sample_hold <= start;
            case (state)
                ST_IDLE: begin
                    // mask and first channel come from the starting write itself
                    if (start) begin
                        state    <= ST_CONV;
                        busy_n   <= 1'b0;
                        run_mask <= scan_mask(sel_mask, wdata);
                        cur_chan <= next_sel(scan_mask(sel_mask, wdata), 3'h7);
                        clk_cnt  <= {CNT_W{1'b0}};
                    end
                end
                ST_CONV: begin
                    // only rising conversion clock edges advance the count
                    if (clk_rise) begin
                        if (clk_cnt == LAST_CNT) begin
                            clk_cnt <= {CNT_W{1'b0}};
                            // busy_n rises at the same edge as the last result lands
                            if (next_sel(run_mask, cur_chan) <= cur_chan) begin
                                state  <= ST_IDLE;
                                busy_n <= 1'b1;
                            end else begin
                                cur_chan <= next_sel(run_mask, cur_chan);
                            end
                        end else begin
                            clk_cnt <= clk_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // mux drive to the analog core
    // ****************************************
    // follows cur_chan, which already holds this write's entry
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_pos    <= 3'h0;
            conv_neg    <= 3'h0;
            conv_pair   <= 1'b0;
            conv_signed <= 1'b0;
        end else begin
            conv_pair   <= pair_en[cur_chan];
            conv_signed <= signed_en[cur_chan];
            if (pair_en[cur_chan] && pair_swap[cur_chan]) begin
                conv_pos <= cur_chan + 3'h1;
                conv_neg <= cur_chan;
            end else begin
                // single-ended slots carry the neighbour as an unused negative input
                conv_pos <= cur_chan;
                conv_neg <= cur_chan + 3'h1;
            end
        end
    end

    // ****************************************
    // result RAM
    // ****************************************
    // a negative unipolar difference has no code, so it is stored as zero
    genvar g;
    generate
        for (g = 0; g < CHANS; g = g + 1) begin : g_ram
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ram[g] <= `RST_BYTE;
                end else if (commit && cur_chan == g) begin
                    // the code is taken as it stands at the commit edge
                    if (conv_pair && !conv_signed && adc_below)
                        ram[g] <= 8'h00;
                    else
                        ram[g] <= adc_code;
                end
            end
        end
    endgenerate

    // ****************************************
    // read pointer
    // ****************************************
    // reads during a scan return old contents for channels not yet committed; a scan end wins over a strobe
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr <= 3'h0;
        end else if (scan_end) begin
            rd_ptr <= next_sel(run_mask, 3'h7);
        end else if (data_wr && w_inh) begin
            rd_ptr <= w_chan;
        end else if (ram_rd) begin
            rd_ptr <= next_sel(sel_mask, rd_ptr);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // rdata stands for the one cycle after the strobe and is zero otherwise
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= `RST_BYTE;
        end else begin
            rdata <= `RST_BYTE;
            if (ram_rd) begin
                rdata <= ram[rd_ptr];
            end else if (rd && addr == `ADDR_STATUS) begin
                // the status byte is built fresh from live state on each read
                rdata[`STAT_PTR_MSB:`STAT_PTR_LSB] <= rd_ptr;
                rdata[`STAT_BUSY]                  <= !busy_n;
                rdata[`STAT_POWER_DOWN]            <= power_down;
            end
        end
    end

endmodule // adc_sequencer

// [inc/adc_seq_map.vh]
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_DATA        1'h0
`define ADDR_STATUS      1'h1

// ****************************************
// configuration byte fields
// ****************************************
`define CFG_CHAN_LSB     0
`define CFG_CHAN_MSB     2
`define CFG_POWER_DOWN   3
`define CFG_INHIBIT      4
`define CFG_SIGNED       5
`define CFG_PAIR         6
`define CFG_SINGLE       7

// ****************************************
// status byte fields
// ****************************************
`define STAT_PTR_LSB     0
`define STAT_PTR_MSB     2
`define STAT_BUSY        3
`define STAT_POWER_DOWN  4

// ****************************************
// reset values and timing
// ****************************************
`define RST_BYTE         8'h00
`define RST_MASK         8'h00
`define CLK_PAIRS        9
`define CLKS_PER_PAIR    2
`define CLKS_PER_CHAN    (`CLK_PAIRS * `CLKS_PER_PAIR)

`endif

// [test/adc_front_model.sv]
`timescale 1ns/100ps
// ****
// converter front end: conversion clock and codes
// ****
module adc_front_model (
    input  wire       clk,
    input  wire       nrst,
    input  wire [2:0] conv_pos,
    input  wire [2:0] conv_neg,
    input  wire       conv_pair,
    input  wire       conv_signed,
    output reg        conv_clk,
    output wire [7:0] adc_code,
    output wire       adc_below
);
    reg [1:0] div;
    // free running at a quarter of clk, as the real input clock never stops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0;
            conv_clk <= 1'b0;
        end else begin
            div <= div + 2'h1;
            conv_clk <= div[1];
        end
    end
    // code names the inputs and the range, so a wrong mux or range shows in the result
    assign adc_code = {1'b1, conv_pos, conv_signed, conv_pair ? conv_neg : 3'h0};
    assign adc_below = conv_pair && (conv_pos > conv_neg);
endmodule // adc_front_model

// [test/adc_seq_properties.sv]
`timescale 1ns/100ps
// ****
// port checker
// ****
module adc_seq_props (
    input wire       clk,
    input wire       nrst,
    input wire       addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       conv_clk,
    input wire       busy_n,
    input wire       sample_hold,
    input wire [2:0] conv_pos,
    input wire [2:0] conv_neg,
    input wire       conv_pair,
    input wire       power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    int   cnt;
    logic cq;
    // conversion clock rises seen during a scan
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            cq <= 1'b0;
        end else begin
            cq <= conv_clk;
            cnt <= busy_n ? 0 : cnt + int'(conv_clk && !cq);
        end
    end
    sequence start_s;
        wr && !addr && !wdata[4] && !wdata[3] && busy_n;
    endsequence
    sequence scan_s;
        !busy_n && sample_hold ##1 !sample_hold;
    endsequence
    start_scan_a: assert property (start_s |=> scan_s) else $error("scan did not start");
    hold_cause_a: assert property (sample_hold |-> $fell(busy_n)) else $error("stray sample");
    scan_len_a: assert property ($rose(busy_n) |-> cnt > 0 && (cnt % 18 == 0 || cnt % 18 == 17))
        else $error("scan length wrong");
    no_restart_a: assert property (!busy_n && wr |=> !sample_hold) else $error("restart in scan");
    inhibit_hold_a: assert property (wr && !addr && wdata[4] && busy_n |=> busy_n) else $error("inhibit start");
    pd_start_a: assert property (wr && wdata[3] && busy_n |=> busy_n) else $error("start when down");
    pd_read_a: assert property (rd && !addr && power_down |=> rdata == 8'h00) else $error("read when down");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata without read");
    pair_adj_a: assert property (conv_pair |-> (conv_pos ^ conv_neg) == 3'h1) else $error("bad pair");
endmodule // adc_seq_props
bind adc_sequencer adc_seq_props i_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .conv_clk(conv_clk), .busy_n(busy_n), .sample_hold(sample_hold), .conv_pos(conv_pos),
    .conv_neg(conv_neg), .conv_pair(conv_pair), .power_down(power_down));

// [test/adc_sequencer_test.sv]
`timescale 1ns/100ps
// ****
// sequencer bench
// ****
module adc_sequencer_test;
    reg        clk, nrst, addr, wr, rd;
    reg  [7:0] wdata;
    wire [7:0] rdata, adc_code;
    wire       conv_clk, adc_below, busy_n, sample_hold, conv_pair, conv_signed, power_down;
    wire [2:0] conv_pos, conv_neg;
    int        n_errors, checks_done;
    adc_sequencer i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .conv_clk(conv_clk), .adc_code(adc_code), .adc_below(adc_below), .busy_n(busy_n),
        .sample_hold(sample_hold), .conv_pos(conv_pos), .conv_neg(conv_neg), .conv_pair(conv_pair),
        .conv_signed(conv_signed), .power_down(power_down));
    adc_front_model i_front (.clk(clk), .nrst(nrst), .conv_pos(conv_pos), .conv_neg(conv_neg),
        .conv_pair(conv_pair), .conv_signed(conv_signed), .conv_clk(conv_clk), .adc_code(adc_code),
        .adc_below(adc_below));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input string what, input [7:0] seen, input [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr_cfg(input a, input [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd_chk(input a, input [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, e);
    endtask
    // start a scan, time it, then read n results and one wrap
    task run(input [7:0] cfg, input [31:0] exp, input int n);
        int cyc, i;
        repeat (80) @(posedge clk); // acquisition gap
        wr_cfg(1'b0, cfg);
        #1 check("busy_n", {7'h0, busy_n}, 8'h00);
        wr_cfg(1'b0, cfg); // ignored restart, same entry
        cyc = 0;
        while (!busy_n && cyc < 1000) begin
            @(posedge clk);
            #1 cyc++;
        end
        check("chans", 8'((cyc + 8) / 72), 8'(n));
        rd_chk(1'b1, 8'h00);
        for (i = 0; i < n; i++) rd_chk(1'b0, exp[8*i +: 8]);
        rd_chk(1'b0, exp[7:0]);
        $display("scan %h done", cfg);
    endtask
    task t_reset;
        check("busy_n", {7'h0, busy_n}, 8'h01);
        rd_chk(1'b1, 8'h00);
        rd_chk(1'b0, 8'h00);
        $display("reset test done");
    endtask
    task t_scan;
        wr_cfg(1'b0, 8'h10);
        wr_cfg(1'b0, 8'h12);
        wr_cfg(1'b0, 8'h35);
        run(8'h25, 32'h00D8A080, 3);
        run(8'h25, 32'h00D8A080, 3);
    endtask
    // a zero on one polarity and a code on the other gives the sign
    task t_pair;
        wr_cfg(1'b0, 8'h51); // pair set up before its starting write
        run(8'h41, 32'h00D8A000, 3);
        run(8'h40, 32'h00D8A081, 3);
        wr_cfg(1'b0, 8'h71);
        run(8'h61, 32'h00D8A098, 3);
        wr_cfg(1'b0, 8'h56);
        run(8'h46, 32'hE7D8A098, 4);
    endtask
    task t_power;
        wr_cfg(1'b0, 8'h18);
        rd_chk(1'b0, 8'h00);
        rd_chk(1'b1, 8'h10);
        wr_cfg(1'b0, 8'h08);
        #1 check("busy_n", {7'h0, busy_n}, 8'h01);
        wr_cfg(1'b0, 8'h35);
        rd_chk(1'b1, 8'h05);
        rd_chk(1'b0, 8'hD8);
        // single-channel start: only the addressed slot, one channel long
        repeat (80) @(posedge clk);
        wr_cfg(1'b0, 8'hA5);
        #1 check("busy_n", {7'h0, busy_n}, 8'h00);
        repeat (80) @(posedge clk);
        #1 check("single", {7'h0, busy_n}, 8'h01);
        rd_chk(1'b1, 8'h05);
        rd_chk(1'b0, 8'hD8);
        $display("power test done");
    endtask
    initial begin
        nrst = 1'b0; addr = 1'b0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        n_errors = 0; checks_done = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_scan;
        t_pair;
        t_power;
        complete_run;
    end
    // about 2100 cycles expected
    initial begin
        #200000;
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        complete_run;
    end
endmodule // adc_sequencer_test
